// [src/oaf_core.v]
// Contract
// [RULE1] flag destination: drop result, update flags
// [RULE2] clear on flags sets only zero
// [RULE3] move/bit/swap ops leave flags alone
// [RULE4] upper three flag bits read zero
// [RULE5] negative follows result msb
// [RULE6] overflow on wrong sign change
// [RULE7] zero flag when result is zero
// [RULE8] half carry from bit three
// [RULE9] carry out of msb
// [RULE10] subtract adds two's complement
// [RULE11] rotate loads carry and half carry
// [RULE12] jump carries 20-bit program address
// [RULE13] 8-bit direct address in low byte
// [RULE14] access bit one joins bank select
// [RULE15] access bit zero uses access bank
// [RULE16] full 12-bit address ignores bank
// [RULE17] destination bit picks file or working
// [RULE18] three 12-bit pointer pairs
// [RULE19] operand registers access pointed location
// [RULE20] indirect address ignores bank and access
// [RULE21] indexed offset only with extended set
// [RULE22] post increment and decrement after access
// [RULE23] pointer carry across bytes, no flags
// [RULE24] flags and write-back commit together
`timescale 1ns/1ns
`include "oaf_defs.vh"
`default_nettype none
module oaf_core (
   // clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // decoded instruction
   input wire exec_valid_in,
   input wire [3:0] opcode_in,
   input wire [7:0] file_addr_in,
   input wire access_sel_in,
   input wire dest_sel_in,
   input wire [2:0] bit_sel_in,
   input wire [7:0] literal_in,
   input wire [11:0] src_long_in,
   input wire [11:0] dst_long_in,
   input wire [11:0] jump_high_in,
   input wire extended_set_enable_in,
   // data ram
   input wire [7:0] ram_rdata_in,
   output wire [11:0] ram_raddr_out,
   output wire [11:0] ram_waddr_out,
   output wire [7:0] ram_wdata_out,
   output wire ram_we_out,
   // core state
   output wire [7:0] alu_flags_out,
   output wire [7:0] working_out,
   output reg [19:0] jump_addr_out,
   output reg jump_valid_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [4:0] flags_reg;
   reg [3:0] bank_select_reg;
   reg [7:0] w_reg;
   reg [11:0] ptr_reg [0:2];
   wire is_file_to_file_move = (opcode_in == `OAF_OP_MOV_FF);
   wire no_file = (opcode_in == `OAF_OP_ADD_LIT) || (opcode_in == `OAF_OP_SUB_LIT) ||
                  (opcode_in == `OAF_OP_JUMP);
   wire live = exec_valid_in && !no_file;

   // ----------------------------------------
   // direct address forming
   // ----------------------------------------
   reg [11:0] eff_addr;
   wire [11:0] src_raw = is_file_to_file_move ? src_long_in : eff_addr;
   wire [11:0] dst_raw = is_file_to_file_move ? dst_long_in : eff_addr;
   // [RULE13] low byte literal address
   always @*
   begin
      // [RULE14] bank joins address
      if (access_sel_in)
         eff_addr = {bank_select_reg, file_addr_in};
      // [RULE21] indexed window only when enabled
      else if (extended_set_enable_in && file_addr_in <= `OAF_INDEX_MAX)
         eff_addr = ptr_reg[2] + {4'h0, file_addr_in};
      // [RULE15] access bank, bank unused
      else if (file_addr_in >= `OAF_ACCESS_SPLIT)
         eff_addr = {4'hf, file_addr_in};
      else
         eff_addr = {4'h0, file_addr_in};
   end

   // ----------------------------------------
   // indirect operand resolution
   // ----------------------------------------
   reg [11:0] src_res;
   reg [11:0] dst_res;
   reg src_virt;
   reg dst_virt;
   integer i;
   // [RULE19] virtual operands redirect through pointer
   // [RULE20] full pointer is the target
   always @*
   begin
      src_res = src_raw;
      dst_res = dst_raw;
      src_virt = 1'b0;
      dst_virt = 1'b0;
      for (i = 0; i < 3; i = i + 1)
      begin
         if (src_raw == `OAF_ADDR_OPND + i[11:0] || src_raw == `OAF_ADDR_INC + i[11:0] ||
             src_raw == `OAF_ADDR_DEC + i[11:0])
         begin
            src_res = ptr_reg[i];
            src_virt = 1'b1;
         end
         if (dst_raw == `OAF_ADDR_OPND + i[11:0] || dst_raw == `OAF_ADDR_INC + i[11:0] ||
             dst_raw == `OAF_ADDR_DEC + i[11:0])
         begin
            dst_res = ptr_reg[i];
            dst_virt = 1'b1;
         end
      end
   end
   // a pointer aimed at another virtual operand reads zero, writes nothing
   wire src_void = src_virt && src_res >= `OAF_ADDR_OPND && src_res <= `OAF_ADDR_VIRT_HI;
   wire dst_void = dst_virt && dst_res >= `OAF_ADDR_OPND && dst_res <= `OAF_ADDR_VIRT_HI;

   // ----------------------------------------
   // operand read
   // ----------------------------------------
   reg [7:0] f_val;
   integer j;
   // [RULE4] unimplemented flag bits read zero
   always @*
   begin
      f_val = ram_rdata_in;
      if (src_void)
         f_val = 8'h00;
      else if (src_res == `OAF_ADDR_FLAGS)
         f_val = {3'h0, flags_reg};
      else if (src_res == `OAF_ADDR_BANK)
         f_val = {4'h0, bank_select_reg};
      for (j = 0; j < 3; j = j + 1)
      begin
         if (!src_void && src_res == `OAF_ADDR_PTR + 2 * j[11:0])
            f_val = ptr_reg[j][7:0];
         if (!src_void && src_res == `OAF_ADDR_PTR + 2 * j[11:0] + 12'h001)
            f_val = {4'h0, ptr_reg[j][11:8]};
      end
   end

   // ----------------------------------------
   // alu
   // ----------------------------------------
   reg [7:0] op_a;
   reg [7:0] op_b;
   reg carry_in;
   reg [7:0] result;
   reg [4:0] new_flags;
   reg [4:0] flag_mask;
   reg to_file;
   wire [8:0] sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};
   wire [4:0] sum5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
   wire [7:0] bit_mask = 8'h01 << bit_sel_in;
   always @*
   begin
      op_a = f_val;
      op_b = w_reg;
      carry_in = 1'b0;
      result = f_val;
      new_flags = flags_reg;
      flag_mask = 5'h00;
      // [RULE17] destination bit chooses file or working
      to_file = dest_sel_in;
      // [RULE10] subtract as add of two's complement
      if (opcode_in == `OAF_OP_SUB_LIT || opcode_in == `OAF_OP_SUB_FILE)
      begin
         op_b = ~w_reg;
         carry_in = 1'b1;
      end
      if (opcode_in == `OAF_OP_ADD_LIT || opcode_in == `OAF_OP_SUB_LIT)
         op_a = literal_in;
      case (opcode_in)
         `OAF_OP_ADD_FILE, `OAF_OP_ADD_LIT, `OAF_OP_SUB_LIT, `OAF_OP_SUB_FILE:
         begin
            result = sum9[7:0];
            flag_mask = 5'h1f;
            // [RULE8] half carry out of bit 3
            new_flags[`OAF_FLAG_DC] = sum5[4];
            // [RULE9] carry out of msb
            new_flags[`OAF_FLAG_C] = sum9[8];
            // [RULE6] signs agree but result flips
            new_flags[`OAF_FLAG_OV] = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
            if (opcode_in == `OAF_OP_ADD_LIT || opcode_in == `OAF_OP_SUB_LIT)
               to_file = 1'b0;
         end
         // [RULE11] rotate through carry
         `OAF_OP_ROT_LEFT:
         begin
            result = {f_val[6:0], flags_reg[`OAF_FLAG_C]};
            flag_mask = 5'h17;
            new_flags[`OAF_FLAG_C] = f_val[7];
            new_flags[`OAF_FLAG_DC] = f_val[3];
         end
         `OAF_OP_ROT_RIGHT:
         begin
            result = {flags_reg[`OAF_FLAG_C], f_val[7:1]};
            flag_mask = 5'h17;
            new_flags[`OAF_FLAG_C] = f_val[0];
            new_flags[`OAF_FLAG_DC] = f_val[4];
         end
         // [RULE2] clear touches only zero
         `OAF_OP_CLEAR:
         begin
            result = 8'h00;
            flag_mask = 5'h04;
            to_file = 1'b1;
         end
         // [RULE3] no flag mask for these
         `OAF_OP_BIT_CLR:
         begin
            result = f_val & ~bit_mask;
            to_file = 1'b1;
         end
         `OAF_OP_BIT_SET:
         begin
            result = f_val | bit_mask;
            to_file = 1'b1;
         end
         `OAF_OP_SWAP:
            result = {f_val[3:0], f_val[7:4]};
         `OAF_OP_MOV_WF:
         begin
            result = w_reg;
            to_file = 1'b1;
         end
         // [RULE16] long address, bank ignored
         `OAF_OP_MOV_FF:
            to_file = 1'b1;
         `OAF_OP_AND_FILE, `OAF_OP_IOR_FILE, `OAF_OP_XOR_FILE:
         begin
            flag_mask = 5'h14;
            if (opcode_in == `OAF_OP_AND_FILE)
               result = f_val & w_reg;
            else if (opcode_in == `OAF_OP_IOR_FILE)
               result = f_val | w_reg;
            else
               result = f_val ^ w_reg;
         end
         default:
            to_file = 1'b0;
      endcase
      // [RULE5] negative from result msb
      new_flags[`OAF_FLAG_N] = result[7];
      // [RULE7] zero when result is zero
      new_flags[`OAF_FLAG_Z] = (result == 8'h00);
      if (opcode_in == `OAF_OP_CLEAR)
         new_flags[`OAF_FLAG_Z] = 1'b1;
   end

   // ----------------------------------------
   // write-back steering
   // ----------------------------------------
   wire file_wr = live && to_file && !dst_void;
   // [RULE1] flag-affecting op on flags drops result
   wire flag_dst = file_wr && dst_res == `OAF_ADDR_FLAGS;
   wire result_wr = file_wr && !(flag_dst && flag_mask != 5'h00);
   wire w_wr = exec_valid_in && !to_file && opcode_in != `OAF_OP_JUMP;
   wire sfr_dst = dst_res >= `OAF_ADDR_FLAGS && dst_res <= `OAF_ADDR_PTR + 12'h005;
   assign ram_raddr_out = src_res;
   assign ram_waddr_out = dst_res;
   assign ram_wdata_out = result;
   assign ram_we_out = result_wr && !sfr_dst;
   assign alu_flags_out = {3'h0, flags_reg};
   assign working_out = w_reg;

   // ----------------------------------------
   // flags, bank, working register
   // ----------------------------------------
   // [RULE24] all results commit on the same edge
   always @(posedge clk_in)
   begin
      if (!reset_n_in)
      begin
         flags_reg <= `OAF_FLAGS_RST;
         bank_select_reg <= `OAF_BANK_RST;
         w_reg <= `OAF_W_RST;
         jump_addr_out <= 20'h00000;
         jump_valid_out <= 1'b0;
      end
      else
      begin
         if (result_wr && dst_res == `OAF_ADDR_FLAGS)
            flags_reg <= result[4:0];
         else if (exec_valid_in)
            flags_reg <= (flags_reg & ~flag_mask) | (new_flags & flag_mask);
         if (result_wr && dst_res == `OAF_ADDR_BANK)
            bank_select_reg <= result[3:0];
         if (w_wr)
            w_reg <= result;
         // [RULE12] 20-bit jump target from instruction
         jump_valid_out <= exec_valid_in && opcode_in == `OAF_OP_JUMP;
         if (exec_valid_in && opcode_in == `OAF_OP_JUMP)
            jump_addr_out <= {jump_high_in, literal_in};
      end
   end

   // ----------------------------------------
   // pointer pairs
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : ptr_gen
         wire hit_inc = live && (src_raw == `OAF_ADDR_INC + g || dst_raw == `OAF_ADDR_INC + g);
         wire hit_dec = live && (src_raw == `OAF_ADDR_DEC + g || dst_raw == `OAF_ADDR_DEC + g);
         wire wr_lo = result_wr && dst_res == `OAF_ADDR_PTR + 2 * g;
         wire wr_hi = result_wr && dst_res == `OAF_ADDR_PTR + 2 * g + 1;
         // [RULE18] 12-bit pointer, upper high bits unused
         // direct writes win over the auto step so a stored value stays put
         always @(posedge clk_in)
         begin
            if (!reset_n_in)
               ptr_reg[g] <= `OAF_PTR_RST;
            else if (wr_lo)
               ptr_reg[g] <= {ptr_reg[g][11:8], result};
            else if (wr_hi)
               ptr_reg[g] <= {result[3:0], ptr_reg[g][7:0]};
            // [RULE22] step after the access
            // [RULE23] whole 12-bit carry, flags untouched
            else if (hit_inc)
               ptr_reg[g] <= ptr_reg[g] + 12'h001;
            else if (hit_dec)
               ptr_reg[g] <= ptr_reg[g] - 12'h001;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [include/oaf_defs.vh]
`ifndef OAF_DEFS_VH
`define OAF_DEFS_VH
// operation codes from the decoder
`define OAF_OP_ADD_FILE 4'h0
`define OAF_OP_ADD_LIT 4'h1
`define OAF_OP_SUB_LIT 4'h2
`define OAF_OP_SUB_FILE 4'h3
`define OAF_OP_ROT_LEFT 4'h4
`define OAF_OP_ROT_RIGHT 4'h5
`define OAF_OP_CLEAR 4'h6
`define OAF_OP_BIT_CLR 4'h7
`define OAF_OP_BIT_SET 4'h8
`define OAF_OP_SWAP 4'h9
`define OAF_OP_MOV_WF 4'ha
`define OAF_OP_MOV_FF 4'hb
`define OAF_OP_AND_FILE 4'hc
`define OAF_OP_IOR_FILE 4'hd
`define OAF_OP_XOR_FILE 4'he
`define OAF_OP_JUMP 4'hf
// special register addresses in the 12-bit data space
`define OAF_ADDR_OPND 12'hfe8
`define OAF_ADDR_INC 12'hfeb
`define OAF_ADDR_DEC 12'hfee
`define OAF_ADDR_FLAGS 12'hff1
`define OAF_ADDR_BANK 12'hff2
`define OAF_ADDR_PTR 12'hff3
`define OAF_ADDR_VIRT_HI 12'hff0
// access bank split and indexed window limit
`define OAF_ACCESS_SPLIT 8'h80
`define OAF_INDEX_MAX 8'h5f
// flag bit positions
`define OAF_FLAG_N 4
`define OAF_FLAG_OV 3
`define OAF_FLAG_Z 2
`define OAF_FLAG_DC 1
`define OAF_FLAG_C 0
// reset values
`define OAF_FLAGS_RST 5'h00
`define OAF_BANK_RST 4'h0
`define OAF_PTR_RST 12'h000
`define OAF_W_RST 8'h00
`endif

// [dv/oaf_core_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "oaf_defs.vh"
// ----------------------------------------
// port checker for the operand and flag core
// ----------------------------------------
module oaf_core_props (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // decoded instruction
   input wire logic exec_valid_in,
   input wire logic [3:0] opcode_in,
   input wire logic [7:0] file_addr_in,
   input wire logic access_sel_in,
   input wire logic dest_sel_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [7:0] literal_in,
   input wire logic [11:0] src_long_in,
   input wire logic [11:0] dst_long_in,
   input wire logic [11:0] jump_high_in,
   input wire logic extended_set_enable_in,
   // data ram
   input wire logic [7:0] ram_rdata_in,
   input wire logic [11:0] ram_raddr_out,
   input wire logic [11:0] ram_waddr_out,
   input wire logic [7:0] ram_wdata_out,
   input wire logic ram_we_out,
   // core state
   input wire logic [7:0] alu_flags_out,
   input wire logic [7:0] working_out,
   input wire logic [19:0] jump_addr_out,
   input wire logic jump_valid_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // decoded strobes keep the properties short
   wire logic lit_add = exec_valid_in && opcode_in == `OAF_OP_ADD_LIT;
   wire logic do_jump = exec_valid_in && opcode_in == `OAF_OP_JUMP;
   wire logic long_mv = exec_valid_in && opcode_in == `OAF_OP_MOV_FF;
   wire logic add_f = exec_valid_in && opcode_in == `OAF_OP_ADD_FILE;
   a_upper_zero: assert property (alu_flags_out[7:5] == 3'h0)
      else $error("flag bits 7:5 not zero");
   a_access_low: assert property (add_f && !access_sel_in && !extended_set_enable_in &&
      file_addr_in < 8'h80 |-> ram_raddr_out == {4'h0, file_addr_in} && ram_we_out == dest_sel_in)
      else $error("access bank address or write select wrong");
   a_long_move: assert property (long_mv && src_long_in < 12'hf00 && dst_long_in < 12'hf00 |->
      ram_raddr_out == src_long_in && ram_we_out && ram_waddr_out == dst_long_in &&
      ram_wdata_out == ram_rdata_in) else $error("long move addresses wrong");
   a_jump_target: assert property (do_jump |=> jump_valid_out &&
      jump_addr_out == {$past(jump_high_in), $past(literal_in)}) else $error("jump target wrong");
   a_jump_cause: assert property (jump_valid_out |-> $past(do_jump))
      else $error("jump valid without jump");
   a_move_flags: assert property (long_mv && dst_long_in != `OAF_ADDR_FLAGS |=>
      $stable(alu_flags_out)) else $error("move changed flags");
   // idle cycles must leave the committed state alone
   a_idle_hold: assert property (!exec_valid_in |=> $stable(alu_flags_out) &&
      $stable(working_out)) else $error("state changed without instruction");
   a_lit_flags: assert property (lit_add |=> alu_flags_out[4] == working_out[7] &&
      alu_flags_out[2] == (working_out == 8'h00) && alu_flags_out[0] == (working_out <
      $past(literal_in))) else $error("literal add flags wrong");
   c_jump: cover property (do_jump);
   c_long: cover property (long_mv);
   c_lit: cover property (lit_add);
endmodule
bind oaf_core oaf_core_props u_props (
   .clk_in, .reset_n_in, .exec_valid_in, .opcode_in, .file_addr_in, .access_sel_in,
   .dest_sel_in, .bit_sel_in, .literal_in, .src_long_in, .dst_long_in, .jump_high_in,
   .extended_set_enable_in, .ram_rdata_in, .ram_raddr_out, .ram_waddr_out, .ram_wdata_out,
   .ram_we_out, .alu_flags_out, .working_out, .jump_addr_out, .jump_valid_out
);
`default_nettype wire

// [dv/oaf_core_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "oaf_defs.vh"
// ----------------------------------------
// bench for the operand and flag core
// ----------------------------------------
module oaf_core_tb_top;
   // stimulus and observed ports
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic exec_valid_in = 1'b0;
   logic access_sel_in = 1'b0, dest_sel_in = 1'b0, extended_set_enable_in = 1'b0;
   logic [3:0] opcode_in = 4'h0;
   logic [2:0] bit_sel_in = 3'h0;
   logic [7:0] file_addr_in = 8'h00, literal_in = 8'h00, ram_rdata_in = 8'h00;
   logic [11:0] src_long_in = 12'h000, dst_long_in = 12'h000, jump_high_in = 12'h000;
   wire logic [11:0] ram_raddr_out, ram_waddr_out;
   wire logic [7:0] ram_wdata_out, alu_flags_out, working_out;
   wire logic [19:0] jump_addr_out;
   wire logic ram_we_out, jump_valid_out;
   // reference copies of working register and flags
   logic [7:0] w_m = 8'h00;
   logic [4:0] fl_m = 5'h00;
   logic [3:0] rop = 4'h0;
   int error_cnt = 0;
   int samples_checked = 0;
   // corner pairs run first: carry to zero, signed overflow, equal subtract, borrow
   localparam logic [31:0] CW = 32'h80450101;
   localparam logic [31:0] CF = 32'h00457fff;
   localparam logic [15:0] CO = 16'h2300;
   oaf_core DUT (
      .clk_in, .reset_n_in, .exec_valid_in, .opcode_in, .file_addr_in, .access_sel_in,
      .dest_sel_in, .bit_sel_in, .literal_in, .src_long_in, .dst_long_in, .jump_high_in,
      .extended_set_enable_in, .ram_rdata_in, .ram_raddr_out, .ram_waddr_out,
      .ram_wdata_out, .ram_we_out, .alu_flags_out, .working_out, .jump_addr_out,
      .jump_valid_out
   );
   // 250 mhz core clock
   always #2 clk_in = ~clk_in;
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // exec is left high so instructions run back to back
   task automatic go(input logic [3:0] op, input logic [7:0] fa, input logic a, input logic d);
      opcode_in = op;
      file_addr_in = fa;
      access_sel_in = a;
      dest_sel_in = d;
      exec_valid_in = 1'b1;
      #2;
   endtask
   task automatic nx();
      @(posedge clk_in);
      #1;
   endtask
   // expected {n, ov, z, dc, c, result}; subtract adds the inverted operand plus one
   function automatic logic [12:0] alu(input logic [3:0] op, input logic [7:0] f, input logic
      [7:0] w, input logic [4:0] fl);
      logic sb;
      logic [7:0] b;
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      sb = (op == `OAF_OP_SUB_LIT || op == `OAF_OP_SUB_FILE);
      b = sb ? ~w : w;
      s = f + b + sb;
      h = f[3:0] + b[3:0] + sb;
      if (op == `OAF_OP_ROT_LEFT)
         return {f[6], fl[3], {f[6:0], fl[0]} == 8'h00, f[3], f[7], f[6:0], fl[0]};
      if (op == `OAF_OP_ROT_RIGHT)
         return {fl[0], fl[3], {fl[0], f[7:1]} == 8'h00, f[4], f[0], fl[0], f[7:1]};
      // logic ops touch only negative and zero
      if (op >= `OAF_OP_AND_FILE && op <= `OAF_OP_XOR_FILE)
      begin
         r = op == `OAF_OP_AND_FILE ? f & w : (op == `OAF_OP_IOR_FILE ? f | w : f ^ w);
         return {r[7], fl[3], r == 8'h00, fl[1:0], r};
      end
      return {s[7], f[7] == b[7] && s[7] != f[7], s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction
   task automatic arith(input logic [3:0] op, input logic [7:0] f, input logic [7:0] fa,
      input logic d);
      logic [12:0] e;
      logic lt;
      e = alu(op, f, w_m, fl_m);
      lt = (op == `OAF_OP_ADD_LIT || op == `OAF_OP_SUB_LIT);
      literal_in = f;
      ram_rdata_in = f;
      go(op, fa, 1'b0, d);
      if (!lt)
      begin
         chk(ram_raddr_out, {4'h0, fa});
         chk(ram_we_out, d);
         if (d)
            chk(ram_wdata_out, e[7:0]);
      end
      nx();
      fl_m = e[12:8];
      if (lt || !d)
         w_m = e[7:0];
      chk(alu_flags_out, fl_m);
      chk(working_out, w_m);
   endtask
   task automatic put(input logic [7:0] fa, input logic [7:0] x);
      arith(`OAF_OP_ADD_LIT, x - w_m, 8'h00, 1'b0);
      go(`OAF_OP_MOV_WF, fa, 1'b0, 1'b0);
      nx();
   endtask
   initial
   begin
      void'($urandom(32'h78ff));
      repeat (2) @(posedge clk_in);
      #1;
      reset_n_in = 1'b1;
      chk(alu_flags_out, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         // random ops span add, subtract, rotate and the three logic ops
         rop = 4'($urandom % 9);
         if (rop > 4'h5)
            rop = rop + 4'h6;
         if (i < 4)
            arith(`OAF_OP_ADD_LIT, CW[i*8 +: 8] - w_m, 8'h00, 1'b0);
         arith(i < 4 ? CO[i*4 +: 4] : rop, i < 4 ? CF[i*8 +: 8] : 8'($urandom),
            8'($urandom % 128), 1'($urandom));
      end
      // flag register written literally, hit by a clear that sets only zero, then bit set and cleared
      put(8'hf1, 8'hea);
      chk(alu_flags_out, 8'h0a);
      go(`OAF_OP_CLEAR, 8'hf1, 1'b0, 1'b1);
      nx();
      chk(alu_flags_out, 8'h0e);
      bit_sel_in = 3'h7;
      go(`OAF_OP_BIT_SET, 8'hf1, 1'b0, 1'b1);
      nx();
      chk(alu_flags_out, 8'h0e);
      bit_sel_in = 3'h3;
      go(`OAF_OP_BIT_CLR, 8'hf1, 1'b0, 1'b1);
      nx();
      chk(alu_flags_out, 8'h06);
      fl_m = 5'h06;
      // an add aimed at the flag register keeps its flags, not its sum (06 + ea)
      go(`OAF_OP_ADD_FILE, 8'hf1, 1'b0, 1'b1);
      nx();
      chk(alu_flags_out, 8'h12);
      fl_m = 5'h12;
      // bank three joins the short address; the access bank ignores it
      put(8'hf2, 8'h03);
      ram_rdata_in = 8'h5a;
      go(`OAF_OP_SWAP, 8'h34, 1'b1, 1'b0);
      chk(ram_raddr_out, 12'h334);
      nx();
      chk(working_out, 8'ha5);
      go(`OAF_OP_SWAP, 8'h90, 1'b0, 1'b0);
      chk(ram_raddr_out, 12'hf90);
      nx();
      w_m = 8'ha5;
      // pointer zero at 2ff crosses the byte boundary on the auto step
      put(8'hf3, 8'hff);
      put(8'hf4, 8'h02);
      bit_sel_in = 3'h0;
      go(`OAF_OP_BIT_SET, 8'heb, 1'b0, 1'b1);
      chk(ram_raddr_out, 12'h2ff);
      chk(ram_waddr_out, 12'h2ff);
      nx();
      chk(alu_flags_out, fl_m);
      go(`OAF_OP_BIT_SET, 8'hee, 1'b0, 1'b1);
      chk(ram_raddr_out, 12'h300);
      nx();
      go(`OAF_OP_BIT_SET, 8'he8, 1'b0, 1'b1);
      chk(ram_raddr_out, 12'h2ff);
      nx();
      src_long_in = 12'h123;
      dst_long_in = 12'h456;
      ram_rdata_in = 8'h3c;
      go(`OAF_OP_MOV_FF, 8'h00, 1'b0, 1'b0);
      chk(ram_waddr_out, 12'h456);
      chk(ram_wdata_out, 8'h3c);
      nx();
      // pointer two at 040 offsets the low access window
      put(8'hf7, 8'h40);
      extended_set_enable_in = 1'b1;
      go(`OAF_OP_SWAP, 8'h10, 1'b0, 1'b0);
      chk(ram_raddr_out, 12'h050);
      nx();
      extended_set_enable_in = 1'b0;
      jump_high_in = 12'habc;
      literal_in = 8'h12;
      go(`OAF_OP_JUMP, 8'h00, 1'b0, 1'b0);
      nx();
      chk(jump_addr_out, 20'habc12);
      chk(jump_valid_out, 1'b1);
      exec_valid_in = 1'b0;
      nx();
      chk(jump_valid_out, 1'b0);
      stop_test();
   end
   // watchdog well beyond the fewer than a hundred cycles the run needs
   initial
   begin
      #20000;
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
